//--- core/lfss_top.sv
`timescale 1ns/1ps
`include "lfss_map.svh"

module lfss_top
	import lfss_pkg::*;
#(
	parameter int SS_CYCLES = `LFSS_SS_TIME_MS * `LFSS_US_PER_MS * `LFSS_CLK_MHZ
) (
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	input  wire logic        en_in,
	input  wire logic [9:0]  led_low_in,
	input  wire logic [9:0]  led_inuse_in,
	input  wire logic [9:0]  led_reg_in,
	input  wire logic [9:0]  led_short_in,
	input  wire logic        ovp_in,
	input  wire logic        ovp90_in,
	input  wire logic        comp_rising_in,
	input  wire logic        in_oc_in,
	input  wire logic        sec_oc_in,
	input  wire logic        sec_ovp_in,
	input  wire logic        uv_in,
	input  wire logic        frequency_set_pin_bad_in,
	input  wire logic        sync_det_in,
	input  wire logic        tsd_in,
	input  wire logic        tsd_cool_in,
	input  wire logic        derate_zone_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic        reg_wr_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        reg_rd_in,
	output logic      [7:0]  reg_rdata_out,
	output logic             disconnect_on_out,
	output logic             boost_en_out,
	output logic             min_on_out,
	output logic      [9:0]  ch_active_out,
	output logic             derate_out,
	output logic             ext_sync_sel_out,
	output logic             fault_flag_out,
	output logic             status_output_one_oe_out,
	output logic             status_output_two_oe_out
);
	localparam int NF = `LFSS_NUM_FAULT;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	lfss_state_e      state_r, state_nxt;
	lfss_cause_e      cause_r, cause_nxt;
	logic [9:0]       mask_r, mask_nxt;
	logic [9:0]       chen_r;
	logic [NF-1:0]    fault_st_r, fault_set, fault_clr;
	logic [9:0]       lreg_r, open_set, lreg_clr;
	logic [NF-1:0]    status_output_one_sel_r, status_output_two_sel_r;
	logic [1:0]       ctrl_r;
	logic             release_w;
	logic             flag_set, flag_clr;
	logic             ss_done;
	logic             regulated;
	logic [9:0]       unreg;
	logic [9:0]       gnd_now;
	logic             sync_prev_r;

	lfss_softstart_timer #(
		.SS_CYCLES (SS_CYCLES)
	) u_ss_timer (
		.mclk_in  (mclk_in),
		.rst_in   (rst_in),
		.run_in   (state_r == LFSS_ST_SOFT),
		.done_out (ss_done)
	);

	assign regulated = &(led_reg_in | ~mask_r);
	assign unreg     = mask_r & ~led_reg_in;
	assign gnd_now   = led_low_in & chen_r;
	assign release_w = reg_wr_in && (reg_addr_in == `LFSS_ADDR_CTRL) &&
	                   reg_wdata_in[`LFSS_CTRL_RELEASE];

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// comparator bits are used directly as synchronous levels
	always_comb begin
		state_nxt = state_r;
		cause_nxt = cause_r;
		mask_nxt  = mask_r;
		fault_set = '0;
		open_set  = '0;
		flag_set  = 1'b0;
		flag_clr  = 1'b0;
		fault_set[`LFSS_F_TWARN] = derate_zone_in;
		fault_set[`LFSS_F_SYNC]  = sync_prev_r && !sync_det_in;
		if (sec_oc_in || sec_ovp_in) begin
			state_nxt = LFSS_ST_DEAD;
			fault_set[`LFSS_F_SECOC] = sec_oc_in;
			fault_set[`LFSS_F_SECOV] = sec_ovp_in;
			flag_set  = 1'b1;
		end else begin
			case (state_r)
				LFSS_ST_OFF: begin
					if (en_in)
						state_nxt = LFSS_ST_CHECK;
				end
				LFSS_ST_DEAD: state_nxt = LFSS_ST_DEAD;
				default: begin
					if (!en_in) begin
						state_nxt = LFSS_ST_OFF;
					end else if (in_oc_in) begin
						state_nxt = LFSS_ST_FAULT;
						cause_nxt = LFSS_C_INOC;
						fault_set[`LFSS_F_INOC] = 1'b1;
						flag_set  = 1'b1;
					end else if (tsd_in) begin
						state_nxt = LFSS_ST_FAULT;
						cause_nxt = LFSS_C_TSD;
						fault_set[`LFSS_F_TSD] = 1'b1;
						flag_set  = 1'b1;
					end else begin
						case (state_r)
							LFSS_ST_CHECK: begin
								if (frequency_set_pin_bad_in) begin
									fault_set[`LFSS_F_FREQUENCY_SET_PIN] = 1'b1;
								end else if (|gnd_now) begin
									fault_set[`LFSS_F_GND] = 1'b1;
								end else begin
									mask_nxt  = led_inuse_in & chen_r;
									state_nxt = LFSS_ST_SOFT;
								end
							end
							LFSS_ST_SOFT: begin
								if (uv_in) begin
									state_nxt = LFSS_ST_FAULT;
									cause_nxt = LFSS_C_UV;
									fault_set[`LFSS_F_UV] = 1'b1;
									flag_set  = 1'b1;
								end else if (ovp90_in || regulated || ss_done) begin
									state_nxt = LFSS_ST_RUN;
								end
							end
							LFSS_ST_RUN: begin
								// drop a string with shorted LEDs
								mask_nxt = mask_r & chen_r & ~led_short_in;
								fault_set[`LFSS_F_LEDSH] = |(led_short_in & mask_r);
								if (ovp_in) begin
									fault_set[`LFSS_F_OVP] = 1'b1;
									if (|(unreg & led_low_in)) begin
										state_nxt = LFSS_ST_LOCK;
										fault_set[`LFSS_F_GND] = 1'b1;
										flag_set  = 1'b1;
									end else begin
										mask_nxt = mask_nxt & ~unreg;
										open_set = unreg;
										fault_set[`LFSS_F_OPEN] = |unreg;
										flag_clr = 1'b1;
									end
								end
							end
							LFSS_ST_FAULT: begin
								case (cause_r)
									LFSS_C_INOC: begin
										if (release_w)
											state_nxt = LFSS_ST_CHECK;
									end
									LFSS_C_UV: begin
										if (!uv_in && (release_w ||
										    !ctrl_r[`LFSS_CTRL_UV_LATCH]))
											state_nxt = LFSS_ST_CHECK;
									end
									LFSS_C_TSD: begin
										if (tsd_cool_in)
											state_nxt = LFSS_ST_CHECK;
									end
									default: state_nxt = LFSS_ST_CHECK;
								endcase
								flag_clr = (state_nxt == LFSS_ST_CHECK);
							end
							default: state_nxt = state_r;
						endcase
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_r <= LFSS_ST_OFF;
			cause_r <= LFSS_C_NONE;
			mask_r  <= '0;
		end else begin
			state_r <= state_nxt;
			cause_r <= cause_nxt;
			mask_r  <= (state_nxt inside {LFSS_ST_SOFT, LFSS_ST_RUN}) ? mask_nxt : '0;
		end
	end

	// ----------------------------------------------------------------
	// Power stage outputs
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			disconnect_on_out <= 1'b0;
			boost_en_out      <= 1'b0;
			min_on_out        <= 1'b0;
			ch_active_out     <= '0;
			derate_out        <= 1'b0;
			ext_sync_sel_out  <= 1'b0;
			sync_prev_r       <= 1'b0;
		end else begin
			// switch held on except when off, in permanent shutdown or after input overcurrent
			disconnect_on_out <= !(state_nxt inside {LFSS_ST_OFF, LFSS_ST_DEAD}) &&
			                     !(state_nxt == LFSS_ST_FAULT && cause_nxt == LFSS_C_INOC);
			// boost and LEDs off outside soft start and run
			boost_en_out  <= state_nxt inside {LFSS_ST_SOFT, LFSS_ST_RUN};
			min_on_out    <= (state_nxt == LFSS_ST_SOFT) && !comp_rising_in;
			ch_active_out <= (state_nxt inside {LFSS_ST_SOFT, LFSS_ST_RUN}) ? mask_nxt : '0;
			derate_out    <= ctrl_r[`LFSS_CTRL_DERATE] && derate_zone_in &&
			                 (state_nxt inside {LFSS_ST_SOFT, LFSS_ST_RUN});
			ext_sync_sel_out <= sync_det_in;
			sync_prev_r      <= sync_det_in;
		end
	end

	// ----------------------------------------------------------------
	// Status, flag and open-drain outputs
	// ----------------------------------------------------------------
	// Status bytes clear on read; a fault arriving that cycle wins
	always_comb begin
		fault_clr = '0;
		lreg_clr  = '0;
		if (reg_rd_in) begin
			case (reg_addr_in)
				`LFSS_ADDR_FAULT_LO: fault_clr[7:0]     = '1;
				`LFSS_ADDR_FAULT_HI: fault_clr[NF-1:8]  = '1;
				`LFSS_ADDR_LREG_LO:  lreg_clr[7:0]      = '1;
				`LFSS_ADDR_LREG_HI:  lreg_clr[9:8]      = '1;
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			fault_st_r     <= '0;
			lreg_r         <= '0;
			fault_flag_out <= 1'b0;
			status_output_one_oe_out    <= 1'b0;
			status_output_two_oe_out    <= 1'b0;
		end else begin
			fault_st_r <= (fault_st_r & ~fault_clr) | fault_set;
			lreg_r     <= (lreg_r & ~lreg_clr) | open_set;
			if (flag_set)
				fault_flag_out <= 1'b1;
			else if (flag_clr)
				fault_flag_out <= 1'b0;
			// pins pulled low on selected status
			status_output_one_oe_out <= |(fault_st_r & status_output_one_sel_r);
			status_output_two_oe_out <= |(fault_st_r & status_output_two_sel_r);
		end
	end

	// ----------------------------------------------------------------
	// Register access
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			chen_r     <= `LFSS_CHEN_RESET;
			status_output_one_sel_r <= `LFSS_SEL_RESET;
			status_output_two_sel_r <= `LFSS_SEL_RESET;
			ctrl_r     <= `LFSS_CTRL_RESET;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				`LFSS_ADDR_CHEN_LO: chen_r[7:0]     <= reg_wdata_in;
				`LFSS_ADDR_CHEN_HI: chen_r[9:8]     <= reg_wdata_in[1:0];
				`LFSS_ADDR_STATUS_OUTPUT_ONE_LO: status_output_one_sel_r[7:0] <= reg_wdata_in;
				`LFSS_ADDR_STATUS_OUTPUT_ONE_HI: status_output_one_sel_r[NF-1:8] <= reg_wdata_in[3:0];
				`LFSS_ADDR_STATUS_OUTPUT_TWO_LO: status_output_two_sel_r[7:0] <= reg_wdata_in;
				`LFSS_ADDR_STATUS_OUTPUT_TWO_HI: status_output_two_sel_r[NF-1:8] <= reg_wdata_in[3:0];
				`LFSS_ADDR_CTRL:    ctrl_r          <= reg_wdata_in[1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			reg_rdata_out <= '0;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				`LFSS_ADDR_CHEN_LO:  reg_rdata_out <= chen_r[7:0];
				`LFSS_ADDR_CHEN_HI:  reg_rdata_out <= {6'h00, chen_r[9:8]};
				`LFSS_ADDR_FAULT_LO: reg_rdata_out <= fault_st_r[7:0];
				`LFSS_ADDR_FAULT_HI: reg_rdata_out <= {4'h0, fault_st_r[NF-1:8]};
				`LFSS_ADDR_LREG_LO:  reg_rdata_out <= lreg_r[7:0];
				`LFSS_ADDR_LREG_HI:  reg_rdata_out <= {6'h00, lreg_r[9:8]};
				`LFSS_ADDR_STATUS_OUTPUT_ONE_LO:  reg_rdata_out <= status_output_one_sel_r[7:0];
				`LFSS_ADDR_STATUS_OUTPUT_ONE_HI:  reg_rdata_out <= {4'h0, status_output_one_sel_r[NF-1:8]};
				`LFSS_ADDR_STATUS_OUTPUT_TWO_LO:  reg_rdata_out <= status_output_two_sel_r[7:0];
				`LFSS_ADDR_STATUS_OUTPUT_TWO_HI:  reg_rdata_out <= {4'h0, status_output_two_sel_r[NF-1:8]};
				`LFSS_ADDR_CTRL:     reg_rdata_out <= {6'h00, ctrl_r};
				default:             reg_rdata_out <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic [31:0] soft_len_r;
	logic        hard_in;
	assign hard_in = sec_oc_in || sec_ovp_in || in_oc_in || tsd_in || !en_in;

	always_ff @(posedge mclk_in) begin
		if (rst_in || state_r != LFSS_ST_SOFT)
			soft_len_r <= '0;
		else
			soft_len_r <= soft_len_r + 32'd1;
	end

	property p_dead;
		@(posedge mclk_in) disable iff (rst_in)
		(sec_oc_in || sec_ovp_in) |=> (state_r == LFSS_ST_DEAD) [*3];
	endproperty
	a_dead: assert property (p_dead) else $error("secondary fault not permanent");

	property p_inoc;
		@(posedge mclk_in) disable iff (rst_in)
		(in_oc_in && en_in && state_r != LFSS_ST_OFF && state_r != LFSS_ST_DEAD)
		|=> !disconnect_on_out && !boost_en_out && fault_flag_out;
	endproperty
	a_inoc: assert property (p_inoc) else $error("input switch not opened");

	property p_gnd_hold;
		@(posedge mclk_in) disable iff (rst_in)
		(state_r == LFSS_ST_CHECK && !hard_in && |gnd_now) |=> !boost_en_out;
	endproperty
	a_gnd_hold: assert property (p_gnd_hold) else $error("soft start with grounded pin");

	property p_frequency_set_pin;
		@(posedge mclk_in) disable iff (rst_in)
		(state_r == LFSS_ST_CHECK && !hard_in && frequency_set_pin_bad_in) |=> state_r == LFSS_ST_CHECK;
	endproperty
	a_frequency_set_pin: assert property (p_frequency_set_pin) else $error("start despite frequency pin fault");

	property p_ss_len;
		@(posedge mclk_in) disable iff (rst_in)
		soft_len_r <= 32'(SS_CYCLES);
	endproperty
	a_ss_len: assert property (p_ss_len) else $error("soft start too long");

	property p_early;
		@(posedge mclk_in) disable iff (rst_in)
		(state_r == LFSS_ST_SOFT && !hard_in && !uv_in && ovp90_in) |=> state_r == LFSS_ST_RUN;
	endproperty
	a_early: assert property (p_early) else $error("soft start not ended early");

	property p_tsd;
		@(posedge mclk_in) disable iff (rst_in)
		(tsd_in && !sec_oc_in && !sec_ovp_in) |=> !boost_en_out && ch_active_out == '0;
	endproperty
	a_tsd: assert property (p_tsd) else $error("drivers on in thermal shutdown");

	property p_derate;
		@(posedge mclk_in) disable iff (rst_in)
		!ctrl_r[`LFSS_CTRL_DERATE] |=> !derate_out;
	endproperty
	a_derate: assert property (p_derate) else $error("derating while disabled");

	property p_open;
		@(posedge mclk_in) disable iff (rst_in)
		(state_r == LFSS_ST_RUN && !hard_in && ovp_in && |unreg && !(|(unreg & led_low_in)))
		|=> ((lreg_r & $past(unreg)) == $past(unreg)) && !fault_flag_out &&
		    ((ch_active_out & $past(unreg)) == '0);
	endproperty
	a_open: assert property (p_open) else $error("open channel not removed");

	property p_lock;
		@(posedge mclk_in) disable iff (rst_in)
		(state_r == LFSS_ST_RUN && !hard_in && ovp_in && |(unreg & led_low_in))
		|=> !boost_en_out ##1 (state_r == LFSS_ST_LOCK || state_r == LFSS_ST_OFF ||
		    state_r == LFSS_ST_DEAD);
	endproperty
	a_lock: assert property (p_lock) else $error("no shutdown on ground short");

	c_run:   cover property (@(posedge mclk_in) disable iff (rst_in)
	         state_r == LFSS_ST_SOFT ##1 state_r == LFSS_ST_RUN);
	c_early: cover property (@(posedge mclk_in) disable iff (rst_in)
	         state_r == LFSS_ST_SOFT && ovp90_in && !regulated);
	c_open:  cover property (@(posedge mclk_in) disable iff (rst_in) |open_set);
	c_dead:  cover property (@(posedge mclk_in) disable iff (rst_in) state_r == LFSS_ST_DEAD);

endmodule : lfss_top

//--- core/lfss_map.svh
`ifndef LFSS_MAP_SVH
`define LFSS_MAP_SVH

// ----------------------------------------------------------------
// Geometry and timing
// ----------------------------------------------------------------
`define LFSS_NUM_CH        10
`define LFSS_NUM_FAULT     12
`define LFSS_CLK_MHZ       25
`define LFSS_SS_TIME_MS    100
`define LFSS_US_PER_MS     1000

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LFSS_ADDR_CHEN_LO  8'h00
`define LFSS_ADDR_CHEN_HI  8'h01
`define LFSS_ADDR_FAULT_LO 8'h38
`define LFSS_ADDR_FAULT_HI 8'h39
`define LFSS_ADDR_LREG_LO  8'h3A
`define LFSS_ADDR_LREG_HI  8'h3B
`define LFSS_ADDR_STATUS_OUTPUT_ONE_LO  8'h40
`define LFSS_ADDR_STATUS_OUTPUT_ONE_HI  8'h41
`define LFSS_ADDR_STATUS_OUTPUT_TWO_LO  8'h42
`define LFSS_ADDR_STATUS_OUTPUT_TWO_HI  8'h43
`define LFSS_ADDR_CTRL     8'h44

// ----------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------
`define LFSS_CTRL_DERATE   0
`define LFSS_CTRL_UV_LATCH 1
`define LFSS_CTRL_RELEASE  7
`define LFSS_CHEN_RESET    10'h3FF
`define LFSS_SEL_RESET     12'h000
`define LFSS_CTRL_RESET    2'h0

// ----------------------------------------------------------------
// Fault status bit positions
// ----------------------------------------------------------------
`define LFSS_F_INOC        0
`define LFSS_F_UV          1
`define LFSS_F_TWARN       2
`define LFSS_F_TSD         3
`define LFSS_F_SECOC       4
`define LFSS_F_SECOV       5
`define LFSS_F_FREQUENCY_SET_PIN        6
`define LFSS_F_OVP         7
`define LFSS_F_OPEN        8
`define LFSS_F_LEDSH       9
`define LFSS_F_SYNC        10
`define LFSS_F_GND         11

`endif

//--- core/lfss_pkg.sv
package lfss_pkg;

	typedef enum logic [2:0] {
		LFSS_ST_OFF   = 3'h0,
		LFSS_ST_CHECK = 3'h1,
		LFSS_ST_SOFT  = 3'h2,
		LFSS_ST_RUN   = 3'h3,
		LFSS_ST_FAULT = 3'h4,
		LFSS_ST_LOCK  = 3'h5,
		LFSS_ST_DEAD  = 3'h6
	} lfss_state_e;

	typedef enum logic [1:0] {
		LFSS_C_NONE = 2'h0,
		LFSS_C_INOC = 2'h1,
		LFSS_C_UV   = 2'h2,
		LFSS_C_TSD  = 2'h3
	} lfss_cause_e;

endpackage : lfss_pkg

//--- core/lfss_softstart_timer.sv
`timescale 1ns/1ps
`include "lfss_map.svh"

module lfss_softstart_timer #(
	parameter int SS_CYCLES = 2
) (
	input  wire logic mclk_in,
	input  wire logic rst_in,
	input  wire logic run_in,
	output logic      done_out
);
	localparam int CW = $clog2(SS_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(SS_CYCLES - 1);

	logic [CW-1:0] cnt_r;

	if (SS_CYCLES < 2) begin : g_chk
		$error("SS_CYCLES must be at least 2");
	end

	// Restarts from zero on every new soft start
	always_ff @(posedge mclk_in) begin
		if (rst_in || !run_in)
			cnt_r <= '0;
		else if (cnt_r != LAST)
			cnt_r <= cnt_r + CW'(1);
	end

	assign done_out = run_in && (cnt_r == LAST);

endmodule : lfss_softstart_timer

//--- sim/lfss_host_model.sv
`timescale 1ns/1ps

module lfss_host_model (
	input  wire logic       mclk_in,
	input  wire logic [7:0] rdata_in,
	output logic      [7:0] addr_out,
	output logic            wr_out,
	output logic      [7:0] wdata_out,
	output logic            rd_out
);
	// ----------------------------------------------------------------
	// Register access
	// ----------------------------------------------------------------
	initial begin
		addr_out  = 8'h00;
		wr_out    = 1'b0;
		wdata_out = 8'h00;
		rd_out    = 1'b0;
	end

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		addr_out  <= a;
		wdata_out <= d;
		wr_out    <= 1'b1;
		@(posedge mclk_in);
		wr_out    <= 1'b0;
		// Released bus shows a changed value, never the stale one
		wdata_out <= ~d;
		addr_out  <= ~a;
	endtask : wr

	// Read data is registered at the strobe edge
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_in);
		addr_out <= a;
		rd_out   <= 1'b1;
		@(posedge mclk_in);
		rd_out   <= 1'b0;
		addr_out <= ~a;
		#1 d = rdata_in;
	endtask : rd
endmodule : lfss_host_model

//--- sim/tb_top.sv
`timescale 1ns/1ps

module tb_top;
	import lfss_pkg::*;
	localparam int SS = 20;
	logic       mclk_in, rst_in, en, overvoltage_threshold, ovp90, comp, in_oc, sec_oc, uv, sovp;
	logic       frequency_set_pin, sync, thermal_shutdown, cool, dz, disc, boost, minon, der, xs, flag, g1, g2;
	logic [9:0] low, inuse, lreg, lsh, act;
	logic [7:0] addr, wd, rdata;
	logic       wr, rd;
	int         fails, checks_done, n;

	// ----------------------------------------------------------------
	// Clock, design and host
	// ----------------------------------------------------------------
	initial begin
		mclk_in = 1'b0;
		forever #20 mclk_in = ~mclk_in;
	end

	lfss_top #(.SS_CYCLES(SS)) dut_u (
		.mclk_in(mclk_in), .rst_in(rst_in), .en_in(en), .led_low_in(low),
		.led_inuse_in(inuse), .led_reg_in(lreg), .led_short_in(lsh), .ovp_in(overvoltage_threshold),
		.ovp90_in(ovp90), .comp_rising_in(comp), .in_oc_in(in_oc), .sec_oc_in(sec_oc),
		.sec_ovp_in(sovp), .uv_in(uv), .frequency_set_pin_bad_in(frequency_set_pin), .sync_det_in(sync),
		.tsd_in(thermal_shutdown), .tsd_cool_in(cool), .derate_zone_in(dz), .reg_addr_in(addr),
		.reg_wr_in(wr), .reg_wdata_in(wd), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.disconnect_on_out(disc), .boost_en_out(boost), .min_on_out(minon),
		.ch_active_out(act), .derate_out(der), .ext_sync_sel_out(xs),
		.fault_flag_out(flag), .status_output_one_oe_out(g1), .status_output_two_oe_out(g2)
	);

	lfss_host_model host_u (
		.mclk_in(mclk_in), .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
		.wdata_out(wd), .rd_out(rd)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task stop_test;
		if (fails == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test

	task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task rchk(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] d;
		host_u.rd(a, d);
		chk(nm, {2'h0, e}, {2'h0, d & m});
	endtask : rchk

	task nx;
		@(posedge mclk_in);
	endtask : nx

	task tick(input int k);
		repeat (k) @(posedge mclk_in);
		#1;
	endtask : tick

	// Bounded wait; the caller compares afterwards
	task wb(input logic v);
		int i;
		for (i = 0; i < 8 && boost !== v; i++) tick(1);
	endtask : wb

	task wm(output int k);
		k = 0;
		while (minon !== 1'b0 && k < 60) begin
			tick(1);
			k++;
		end
	endtask : wm

	initial begin
		#120000;
		fails++;
		stop_test;
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{en, overvoltage_threshold, ovp90, comp, in_oc, sec_oc, uv, sovp, frequency_set_pin, sync, thermal_shutdown, cool, dz} = '0;
		{low, lreg, lsh} = '0;
		inuse = 10'h0FF;
		fails = 0;
		checks_done = 0;
		rst_in = 1'b1;
		repeat (2) nx;
		rst_in <= 1'b0;
		tick(1);
		chk("boost", 0, boost);
		chk("active", 0, act);
		rchk("chen_lo", 8'h00, 8'hFF, 8'hFF);
		rchk("chen_hi", 8'h01, 8'hFF, 8'h03);
		rchk("unmapped", 8'h10, 8'hFF, 8'h00);
		host_u.wr(8'h00, 8'hFE);
		host_u.wr(8'h40, 8'h80);
		host_u.wr(8'h43, 8'h01);
		nx;
		low <= 10'h008;
		en <= 1'b1;
		tick(1);
		chk("disconnect", 1, disc);
		tick(4);
		chk("boost", 0, boost);
		nx;
		low <= 10'h000;
		tick(1);
		chk("boost", 1, boost);
		chk("active", 10'h0FE, act);
		chk("min_on", 1, minon);
		wm(n);
		chk("ss_len", 1, 10'(n >= SS - 3 && n <= SS + 2));
		nx;
		sync <= 1'b1;
		tick(1);
		chk("ext_sync", 1, xs);
		nx;
		sync <= 1'b0;
		tick(1);
		chk("ext_sync", 0, xs);
		nx;
		dz <= 1'b1;
		tick(1);
		chk("derate", 0, der);
		host_u.wr(8'h44, 8'h01);
		tick(1);
		chk("derate", 1, der);
		nx;
		dz <= 1'b0;
		lreg <= 10'h0FC;
		lsh <= 10'h004;
		tick(1);
		chk("active", 10'h0FA, act);
		nx;
		lsh <= 10'h000;
		overvoltage_threshold <= 1'b1;
		nx;
		overvoltage_threshold <= 1'b0;
		#1;
		chk("active", 10'h0F8, act);
		chk("flag", 0, flag);
		// Open-drain enables follow the status register one cycle later
		tick(1);
		chk("status_output_one", 1, g1);
		chk("status_output_two", 1, g2);
		rchk("lreg", 8'h3A, 8'h02, 8'h02);
		rchk("lreg", 8'h3A, 8'h02, 8'h00);
		rchk("fault_lo", 8'h38, 8'h80, 8'h80);
		rchk("fault_hi", 8'h39, 8'h03, 8'h03);
		tick(1);
		chk("status_output_one", 0, g1);
		chk("status_output_two", 0, g2);
		nx;
		thermal_shutdown <= 1'b1;
		tick(1);
		chk("boost", 0, boost);
		chk("active", 0, act);
		nx;
		thermal_shutdown <= 1'b0;
		tick(3);
		chk("boost", 0, boost);
		nx;
		cool <= 1'b1;
		wb(1);
		chk("boost", 1, boost);
		chk("min_on", 1, minon);
		nx;
		cool <= 1'b0;
		comp <= 1'b1;
		tick(1);
		chk("min_on", 0, minon);
		nx;
		comp <= 1'b0;
		tick(1);
		chk("min_on", 1, minon);
		nx;
		ovp90 <= 1'b1;
		wm(n);
		chk("ovp90_end", 1, 10'(n <= 2));
		nx;
		ovp90 <= 1'b0;
		en <= 1'b0;
		tick(1);
		chk("disconnect", 0, disc);
		nx;
		en <= 1'b1;
		wb(1);
		nx;
		uv <= 1'b1;
		tick(1);
		chk("boost", 0, boost);
		chk("flag", 1, flag);
		nx;
		uv <= 1'b0;
		wb(1);
		chk("boost", 1, boost);
		nx;
		lreg <= 10'h3FF;
		wm(n);
		chk("reg_end", 1, 10'(n <= 3));
		nx;
		in_oc <= 1'b1;
		tick(1);
		chk("disconnect", 0, disc);
		chk("flag", 1, flag);
		nx;
		in_oc <= 1'b0;
		lreg <= 10'h000;
		tick(5);
		chk("boost", 0, boost);
		host_u.wr(8'h44, 8'h80);
		wb(1);
		chk("boost", 1, boost);
		// Latched undervoltage mode needs a release write
		host_u.wr(8'h44, 8'h02);
		nx;
		uv <= 1'b1;
		nx;
		uv <= 1'b0;
		tick(4);
		chk("boost", 0, boost);
		host_u.wr(8'h44, 8'h82);
		wb(1);
		chk("boost", 1, boost);
		nx;
		en <= 1'b0;
		frequency_set_pin <= 1'b1;
		nx;
		en <= 1'b1;
		tick(5);
		chk("boost", 0, boost);
		nx;
		frequency_set_pin <= 1'b0;
		wb(1);
		chk("boost", 1, boost);
		wm(n);
		nx;
		lreg <= 10'h3FD;
		low <= 10'h002;
		overvoltage_threshold <= 1'b1;
		nx;
		overvoltage_threshold <= 1'b0;
		tick(1);
		chk("boost", 0, boost);
		nx;
		en <= 1'b0;
		nx;
		en <= 1'b1;
		tick(5);
		chk("boost", 0, boost);
		nx;
		low <= 10'h000;
		wb(1);
		chk("boost", 1, boost);
		nx;
		sec_oc <= 1'b1;
		nx;
		sec_oc <= 1'b0;
		tick(1);
		chk("boost", 0, boost);
		nx;
		en <= 1'b0;
		nx;
		en <= 1'b1;
		tick(6);
		chk("boost", 0, boost);
		// Only a reset leaves the permanent shutdown
		nx;
		rst_in <= 1'b1;
		repeat (2) nx;
		rst_in <= 1'b0;
		wb(1);
		chk("boost", 1, boost);
		chk("active", 10'h0FF, act);
		nx;
		sovp <= 1'b1;
		nx;
		sovp <= 1'b0;
		tick(1);
		chk("boost", 0, boost);
		rchk("fault_lo", 8'h38, 8'h30, 8'h20);
		stop_test;
	end
endmodule : tb_top
